// File: ods_sync_ctrl.sv
`include "ods_defines.svh"
module ods_sync_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic align_n_i,
  input wire logic chip_power_down_n_i,
  input wire logic osc_cal_busy_i,
  input wire logic soft_sync_i,
  input wire logic soft_reset_i,
  input wire logic dist_pd_i,
  input wire logic update_all_i,
  input wire logic [`ODS_NUM_CH-1:0] channel_exclude_i,
  input wire logic [`ODS_NUM_CH-1:0] channel_start_high_i,
  input wire logic [4*`ODS_NUM_CH-1:0] channel_phase_offset_i,
  input wire logic [`ODS_NUM_CH-1:0] ch_clk_i,
  input wire logic [`ODS_NUM_PECL-1:0] pecl_invert_i,
  input wire logic [2*`ODS_NUM_PECL-1:0] pecl_pd_mode_i,
  input wire logic [`ODS_NUM_LVD-1:0] lvd_cmos_mode_i,
  input wire logic [`ODS_NUM_LVD-1:0] lvd_invert_i,
  input wire logic [3*`ODS_NUM_LVD-1:0] cmos_pol_i,
  input wire logic [`ODS_NUM_LVD-1:0] cmos_leg_b_en_i,
  input wire logic [`ODS_NUM_LVD-1:0] lvd_pd_i,
  input wire logic [6*`ODS_NUM_LVD-1:0] fine_frac_i,
  input wire logic [6*`ODS_NUM_LVD-1:0] fine_half_i,
  output logic [`ODS_NUM_PECL-1:0] pecl_clk_o,
  output logic [`ODS_NUM_LVD-1:0] lvd_p_o,
  output logic [`ODS_NUM_LVD-1:0] lvd_n_o,
  output logic [`ODS_NUM_LVD-1:0] cmos_leg_a_o,
  output logic [`ODS_NUM_LVD-1:0] cmos_leg_b_o,
  output logic align_busy_o,
  output logic [5*`ODS_NUM_CH-1:0] coarse_phase_o
);
  ods_pkg::ods_st_t st_reg;
  ods_pkg::ods_st_t st_next;
  logic soft_latched_reg;
  logic soft_latched_next;
  logic [5*`ODS_NUM_CH-1:0] phase_reg;
  logic [5*`ODS_NUM_CH-1:0] phase_next;
  logic [`ODS_NUM_CH-1:0] ch_out;
  logic [`ODS_NUM_LVD-1:0] stop_lvd;
  logic soft_req;
  logic hold_req;

  // ************************************************************
  // per-channel preset and exclusion
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < `ODS_NUM_CH; g++)
    begin : g_ch
      assign phase_next[5*g +: 5] = {channel_start_high_i[g],
                                     channel_phase_offset_i[4*g +: 4]};
      assign ch_out[g] = (st_reg.preset && !channel_exclude_i[g]) ?
                         channel_start_high_i[g] : ch_clk_i[g];
    end
    for (g = 0; g < `ODS_NUM_LVD; g++)
    begin : g_fd
      assign stop_lvd[g] = fine_frac_i[6*g +: 6] > fine_half_i[6*g +: 6];
    end
  endgenerate

  assign soft_latched_next = update_all_i ? soft_sync_i : soft_latched_reg;
  assign soft_req = soft_latched_reg | soft_reset_i | dist_pd_i;
  assign hold_req = !st_reg.sync_s | st_reg.cal_s | soft_req |
                    !chip_power_down_n_i | !st_reg.por_done;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.sync_meta = align_n_i;
    st_next.sync_s = st_reg.sync_meta;
    st_next.cal_meta = osc_cal_busy_i;
    st_next.cal_s = st_reg.cal_meta;
    st_next.soft_prev = soft_req;
    st_next.por_done = 1'b1;
    unique case (st_reg.state)
      ods_pkg::ODS_RUN:
      begin
        if (hold_req)
        begin
          st_next.state = ods_pkg::ODS_HOLD;
          st_next.preset = 1'b1;
        end
      end
      ods_pkg::ODS_HOLD:
      begin
        if (!hold_req)
        begin
          st_next.state = ods_pkg::ODS_WAIT;
          st_next.cnt = 5'h00;
        end
      end
      ods_pkg::ODS_WAIT:
      begin
        if (hold_req)
        begin
          st_next.state = ods_pkg::ODS_HOLD;
        end
        // wait absorbs the sync pipeline so pin-to-clock latency holds
        else if (st_reg.cnt == (`ODS_REL_LAT - `ODS_SYNC_DLY))
        begin
          st_next.state = ods_pkg::ODS_RUN;
          st_next.preset = 1'b0;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 5'h01;
        end
      end
    endcase
    for (int i = 0; i < `ODS_NUM_PECL; i++)
    begin
      st_next.pecl_clk[i] =
        (pecl_pd_mode_i[2*i +: 2] == `ODS_PD_NORMAL) &&
        (ch_out[i/2] ^ pecl_invert_i[i]);
    end
    for (int i = 0; i < `ODS_NUM_LVD; i++)
    begin
      if (lvd_pd_i[i] || stop_lvd[i])
      begin
        st_next.lvd_p[i] = 1'b0;
        st_next.lvd_n[i] = 1'b0;
        st_next.leg_a[i] = 1'b0;
        st_next.leg_b[i] = 1'b0;
      end
      else if (lvd_cmos_mode_i[i])
      begin
        st_next.lvd_p[i] = 1'b0;
        st_next.lvd_n[i] = 1'b0;
        st_next.leg_a[i] = ch_out[`ODS_LVD_BASE + i/2] ^ cmos_pol_i[3*i];
        st_next.leg_b[i] = cmos_leg_b_en_i[i] &&
          (ch_out[`ODS_LVD_BASE + i/2] ^ cmos_pol_i[3*i + 1]);
      end
      else
      begin
        st_next.lvd_p[i] = ch_out[`ODS_LVD_BASE + i/2] ^ lvd_invert_i[i];
        st_next.lvd_n[i] = !(ch_out[`ODS_LVD_BASE + i/2] ^ lvd_invert_i[i]);
        st_next.leg_a[i] = 1'b0;
        st_next.leg_b[i] = 1'b0;
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
      soft_latched_reg <= 1'b0;
      phase_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      soft_latched_reg <= soft_latched_next;
      phase_reg <= phase_next;
    end
  end

  // outputs straight from flip-flops
  assign pecl_clk_o = st_reg.pecl_clk;
  assign lvd_p_o = st_reg.lvd_p;
  assign lvd_n_o = st_reg.lvd_n;
  assign cmos_leg_a_o = st_reg.leg_a;
  assign cmos_leg_b_o = st_reg.leg_b;
  assign align_busy_o = st_reg.preset;
  assign coarse_phase_o = phase_reg;

  // ************************************************************
  // checks
  // ************************************************************
  // last count of the wait with every source gone
  sequence s_release;
    st_reg.state == ods_pkg::ODS_WAIT
      && st_reg.cnt == (`ODS_REL_LAT - `ODS_SYNC_DLY) && !hold_req;
  endsequence
  // pin release seen with no other source left
  sequence s_pin_rise;
    $rose(st_reg.sync_s) && st_reg.state == ods_pkg::ODS_HOLD
      && !st_reg.cal_s && !soft_req && chip_power_down_n_i;
  endsequence
  AST_RELEASE_LAT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_pin_rise |-> ##13 !st_reg.preset)
    else $error("release latency wrong");
  AST_RELEASE_NOW: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    s_release |=> !st_reg.preset)
    else $error("preset not released");
  AST_HOLD_PIN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st_reg.sync_s |=> st_reg.preset)
    else $error("pin low did not preset");
  AST_HOLD_CAL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.cal_s |=> st_reg.preset)
    else $error("calibration did not hold");
  AST_SOFT_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    soft_req |=> st_reg.preset)
    else $error("soft request did not hold");
  AST_WAKE_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !chip_power_down_n_i |=> st_reg.preset)
    else $error("power-down did not hold");
  AST_POR_SYNC: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st_reg.por_done |=> st_reg.preset)
    else $error("no power-up alignment");
  AST_UPDATE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !update_all_i |=> $stable(soft_latched_reg))
    else $error("soft sync changed without update");
  AST_LEGB_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !cmos_leg_b_en_i[0] |=> !cmos_leg_b_o[0])
    else $error("leg b on while disabled");
  AST_PD_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    lvd_pd_i[0] |=> !cmos_leg_a_o[0] && !lvd_p_o[0] && !lvd_n_o[0])
    else $error("powered-down output active");

  // ************************************************************
  // preset hold and output stage checks
  // ************************************************************
  // a soft request seen last cycle keeps the preset up
  AST_SOFT_PREV: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.soft_prev |-> st_reg.preset)
    else $error("soft request released too early");
  // any non-normal pecl mode silences the output
  AST_PECL_PD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pecl_pd_mode_i[1:0] != `ODS_PD_NORMAL |=> !pecl_clk_o[0])
    else $error("powered-down pecl output active");
  // excluded channel follows its divider even during preset
  AST_EXCL_FREE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    channel_exclude_i[0] && pecl_pd_mode_i[1:0] == `ODS_PD_NORMAL
      |=> pecl_clk_o[0] == ($past(ch_clk_i[0]) ^ $past(pecl_invert_i[0])))
    else $error("excluded output held");
  AST_PRESET_LVL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_reg.preset && !channel_exclude_i[1]
      && pecl_pd_mode_i[5:4] == `ODS_PD_NORMAL
      |=> pecl_clk_o[2] == ($past(channel_start_high_i[1])
        ^ $past(pecl_invert_i[2])))
    else $error("preset level wrong");
  // differential legs and fine-delay stop
  AST_LVD_COMPL: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !lvd_cmos_mode_i[0] && !lvd_pd_i[0] && !stop_lvd[0]
      |=> lvd_n_o[0] != lvd_p_o[0])
    else $error("differential legs not complementary");
  AST_FINE_STOP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    stop_lvd[0] |=> !lvd_p_o[0] && !lvd_n_o[0] && !cmos_leg_a_o[0])
    else $error("over-long fine delay still clocking");
endmodule // ods_sync_ctrl

// File: ods_defines.svh
`ifndef ODS_DEFINES_SVH
`define ODS_DEFINES_SVH
// channel counts
`define ODS_NUM_PECL 6
`define ODS_NUM_LVD 4
`define ODS_NUM_CH 5
// fine-delay fraction limit
`define ODS_FRAC_MAX 6'h2F
// release latency in divider-input cycles
`define ODS_REL_LAT 5'h0E
// pipeline ahead of the wait count: two sync stages and hold exit
`define ODS_SYNC_DLY 5'h03
// first channel feeding the lvds/cmos outputs
`define ODS_LVD_BASE 3
// coarse phase start-high weight position
`define ODS_PH_SH_BIT 4
// half-period limit for fine delay, in fraction units
`define ODS_HALF_DEF 6'h1F
// pecl power-down mode codes
`define ODS_PD_NORMAL 2'h0
`define ODS_PD_SAFE 2'h2
`define ODS_PD_TOTAL 2'h3
`endif

// File: ods_pkg.sv
package ods_pkg;
  typedef enum logic [1:0] {ODS_RUN, ODS_HOLD, ODS_WAIT} ods_state_t;
  typedef struct packed {
    ods_state_t state;
    logic [4:0] cnt;
    logic sync_meta;
    logic sync_s;
    logic cal_meta;
    logic cal_s;
    logic soft_prev;
    logic por_done;
    logic preset;
    logic [5:0] pecl_clk;
    logic [3:0] lvd_p;
    logic [3:0] lvd_n;
    logic [3:0] leg_a;
    logic [3:0] leg_b;
  } ods_st_t;
endpackage

// File: ods_rx_model.sv
// ***********************************
// receiver standing on the pecl clock outputs
// ***********************************
module ods_rx_model (
  input wire logic core_clk_i,
  input wire logic clr_i,
  input wire logic [5:0] pecl_clk_i,
  output logic [5:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] last_reg;
  // flag any level change on each output since last clear
  always_ff @(posedge core_clk_i)
  begin
    last_reg <= pecl_clk_i;
    seen_o <= clr_i ? 6'h00 : (seen_o | (pecl_clk_i ^ last_reg));
  end
endmodule // ods_rx_model

// File: output_divider_sync_and_config_bench.sv
module output_divider_sync_and_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, rst_n_i, align_n_i, chip_power_down_n_i;
  logic osc_cal_busy_i, soft_sync_i, soft_reset_i, dist_pd_i;
  logic update_all_i, clr, v, w, busy;
  logic [4:0] excl, sh, ch_clk;
  logic [19:0] po;
  logic [5:0] pinv, pecl, seen;
  logic [11:0] pmode, cpol;
  logic [3:0] cmode, linv, legb_en, lpd, lp, ln, la, lb;
  logic [23:0] frac, half;
  logic [24:0] cph;
  logic [31:0] rnd;
  int errors, total_checks, n, k, i, j;
  // ***********************************
  // clock, design and receiver
  // ***********************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) ch_clk <= ~ch_clk;
  ods_sync_ctrl dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .align_n_i(align_n_i), .chip_power_down_n_i(chip_power_down_n_i),
    .osc_cal_busy_i(osc_cal_busy_i), .soft_sync_i(soft_sync_i),
    .soft_reset_i(soft_reset_i), .dist_pd_i(dist_pd_i),
    .update_all_i(update_all_i), .channel_exclude_i(excl),
    .channel_start_high_i(sh), .channel_phase_offset_i(po),
    .ch_clk_i(ch_clk), .pecl_invert_i(pinv), .pecl_pd_mode_i(pmode),
    .lvd_cmos_mode_i(cmode), .lvd_invert_i(linv), .cmos_pol_i(cpol),
    .cmos_leg_b_en_i(legb_en), .lvd_pd_i(lpd), .fine_frac_i(frac),
    .fine_half_i(half), .pecl_clk_o(pecl), .lvd_p_o(lp), .lvd_n_o(ln),
    .cmos_leg_a_o(la), .cmos_leg_b_o(lb), .align_busy_o(busy),
    .coarse_phase_o(cph));
  ods_rx_model rx (.core_clk_i(core_clk_i), .clr_i(clr),
    .pecl_clk_i(pecl), .seen_o(seen));
  // ***********************************
  // helpers
  // ***********************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic lvl(input logic s, input logic p);
    return s ^ p;
  endfunction
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic wait_busy(input logic w);
    n = 0;
    while (busy !== w && n < 60)
    begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic src(input int s, input logic on);
    @(posedge core_clk_i);
    case (s)
      0: soft_reset_i <= on;
      1: dist_pd_i <= on;
      2: chip_power_down_n_i <= ~on;
      3: osc_cal_busy_i <= on;
      default: align_n_i <= ~on;
    endcase
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ***********************************
  // stimulus and checks
  // ***********************************
  initial
  begin
    {rst_n_i, soft_sync_i, soft_reset_i, dist_pd_i, update_all_i} = 5'h00;
    {align_n_i, chip_power_down_n_i, osc_cal_busy_i, clr} = 4'hC;
    {ch_clk, pmode, cmode, lpd, cpol, legb_en} = 41'h0;
    half = 24'hFFFFFF;
    rnd = 32'he93d14e6;
    {excl, sh, po, pinv, linv, frac} = 64'h0;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 2; k++)
    begin
      wait_busy(1'b1);
      chk(n <= 2, "no power-up align");
      wait_busy(1'b0);
      chk(n >= 14 && n <= 20, "power-up release");
      @(posedge core_clk_i);
      rnd = lfsr(rnd);
      excl <= {rnd[4:2], 2'h1};
      {sh, pinv, linv} <= rnd[31:17];
      po <= rnd[19:0];
      for (i = 0; i < 4; i++)
        frac[6*i+:6] <= 6'(rnd[i*6+:6] % 32'h30);
      repeat (2) @(negedge core_clk_i);
      for (i = 0; i < 5; i++)
        chk(cph[5*i+:5] === {sh[i], po[4*i+:4]}, "coarse");
      // pin align: preset levels, excluded pair keeps running
      src(4, 1'b1);
      clr <= 1'b1;
      wait_busy(1'b1);
      chk(n <= 4, "pin hold");
      clr <= 1'b0;
      repeat (8) @(negedge core_clk_i);
      chk(seen[1:0] === 2'h3, "excluded stopped");
      for (i = 2; i < 6; i++)
        if (!excl[i/2])
          chk(pecl[i] === lvl(sh[i/2], pinv[i]), "pecl");
      for (i = 0; i < 4; i++)
        if (!excl[3+i/2])
          chk(lp[i] === lvl(sh[3+i/2], linv[i]) && ln[i] === ~lp[i],
            "lvds preset");
      src(4, 1'b0);
      wait_busy(1'b0);
      chk(n >= 15 && n <= 17, "pin release");
      // soft align bit waits for the update command
      @(posedge core_clk_i);
      soft_sync_i <= 1'b1;
      repeat (20) @(negedge core_clk_i);
      chk(busy === 1'b0, "sync without update");
      for (i = 0; i < 2; i++)
      begin
        @(posedge core_clk_i);
        update_all_i <= 1'b1;
        @(posedge core_clk_i);
        update_all_i <= 1'b0;
        soft_sync_i <= 1'b0;
      end
      wait_busy(1'b1);
      chk(n <= 40, "soft align");
      wait_busy(1'b0);
      // each other source, overlapped with the pin
      for (i = 0; i < 4; i++)
      begin
        src(i, 1'b1);
        src(4, 1'b1);
        wait_busy(1'b1);
        chk(n <= 5, "source hold");
        src(i, 1'b0);
        repeat (25) @(negedge core_clk_i);
        chk(busy === 1'b1, "early release");
        src(4, 1'b0);
        wait_busy(1'b0);
        chk(n <= 20, "no release");
      end
      // output power-down modes and single-ended legs
      for (i = 1; i < 4; i++)
      begin
        @(posedge core_clk_i);
        pmode <= {6{2'(i)}};
        cmode <= 4'hF;
        legb_en <= rnd[3:0];
        lpd <= {4{i[0]}};
        cpol <= rnd[15:4];
        repeat (3) @(negedge core_clk_i);
        chk(pecl === 6'h00, "pecl off");
        chk((lb & ~legb_en) === 4'h0, "leg b");
        if (i[0])
          chk({la, lb, lp, ln} === 16'h0, "lvd off");
        else
          for (j = 0; j < 4; j++)
            chk(la[j] === (~ch_clk[3+j/2] ^ cpol[3*j]) && lb[j] ===
              (legb_en[j] & (~ch_clk[3+j/2] ^ cpol[3*j+1])),
              "cmos legs");
      end
      @(posedge core_clk_i);
      {pmode, cmode, lpd} <= 20'h0;
      // over-long fine delay stops the output, its neighbour runs on
      excl <= 5'h00;
      frac[5:0] <= 6'h2F;
      half[5:0] <= 6'h00;
      repeat (4) @(negedge core_clk_i);
      v = lp[0];
      w = lp[1];
      repeat (7) @(negedge core_clk_i);
      chk(lp[0] === v, "fine delay");
      chk(lp[1] === ~w, "fine delay in range");
      @(posedge core_clk_i);
      half <= 24'hFFFFFF;
      // second pass starts with a chip reset in mid-run
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
    end
    final_report();
  end
  // hang guard
  initial
  begin
    #400000;
    errors++;
    final_report();
  end
endmodule // output_divider_sync_and_config_bench
